// ---- src/rsr_ramp_ctrl.sv ----
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - Parabolic step adds step index times deviation
// - Parabolic ramp only while its enable set
// - Fast ramp: separate up and down parameters
// - Fast ramp needs enable and triangular type
// - Select bits choose up or down set
// - Ramp start bit begins the sweep
// - Ramp complete shown on output pin
// - External step mode advances on trigger pulse
// - Interrupt on trigger rising edge when selected
// - Interrupt mode off, run, or halt
// - Readback only while a ramp runs
// - Interrupt captures 37-bit integer and fraction
// - Readback bit shifted on serial clock rise
// - Integer/fraction write starts fast lock interval
// - Interval equals first times second divider
// - No fast lock while ramping
// - Fast lock boosts pump, closes switch pins
// - Modulator clocked once per detector cycle
module rsr_ramp_ctrl
   import rsr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   input wire logic trigger_pin,
   input wire logic readback_clk_pin,
   output logic multiplexed_output_pin,
   output logic first_switch_pin_short,
   output logic second_switch_pin_link,
   output logic [4:0] cp_current_mult,
   output logic signed [3:0] div_offset
);
   logic aw_have_q, w_have_q;
   logic [ADDR_W-1:0] waddr_q;
   logic [DATA_W-1:0] wdata_q, wd_m;
   logic [3:0] wstrb_q;
   logic wr_fire, r0_wr, fl_start;
   logic [31:0] r0_q, r1_q, r2_q, r3_q, r4_q, r5_q, r6_q, r7_q;
   logic [11:0] second_clock_divider_q [2];
   logic [15:0] dev_q [2];
   logic [3:0] shf_q [2];
   logic [19:0] steps_q [2];
   logic [2:0] pfd_cnt_q;
   logic pfd_tick;
   logic trig_s1_q, trig_s2_q, trig_s3_q, rck_s1_q, rck_s2_q, rck_s3_q;
   logic trig_rise, rck_rise;
   rsr_ramp_state_type st_q;
   logic [N_W-1:0] freq_q, base_q, shreg_q;
   logic [19:0] step_idx_q;
   logic [23:0] timer_q, fl_cnt_q;
   logic done_q, halted_q;
   logic [5:0] sh_cnt_q;
   logic running, fast_on, ramp_set, parab_on, ext_on, step_ev, step_end;
   logic int_fire, fl_active;
   logic [1:0] rtype;
   logic signed [N_W-1:0] dev_w, inc_w;
   logic [N_W-1:0] n_word;
   logic [31:0] stat_w;
   rsr_sd_if sd ();

   function automatic logic [DATA_W-1:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] v;
      v = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            v[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return v;
   endfunction : merge

   function automatic logic [DATA_W-1:0] reg_read(input logic [5:0] a);
      logic [31:0] v;
      v = '0;
      case ({a[5:2], 2'b00})
         OFS_R0: v = r0_q;
         OFS_R1: v = r1_q;
         OFS_R2: v = r2_q;
         OFS_R3: v = r3_q;
         OFS_R4: v = r4_q;
         OFS_R5: v = r5_q;
         OFS_R6: v = r6_q;
         OFS_R7: v = r7_q;
         OFS_STAT: v = stat_w;
         default: v = '0;
      endcase
      return v;
   endfunction : reg_read

   function automatic logic mapped(input logic [5:0] a);
      return {a[5:2], 2'b00} <= OFS_STAT;
   endfunction : mapped

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   assign awready = !aw_have_q && !bvalid;
   assign wready = !w_have_q && !bvalid;
   assign arready = !rvalid;
   assign wr_fire = aw_have_q && w_have_q && !bvalid;
   assign wd_m = merge(reg_read(waddr_q), wdata_q, wstrb_q);
   assign r0_wr = wr_fire && ({waddr_q[5:2], 2'b00} == OFS_R0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         waddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            waddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= reg_read(araddr);
         rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {r0_q, r1_q, r2_q, r3_q, r4_q, r5_q, r6_q, r7_q} <= '0;
         second_clock_divider_q <= '{default: '0};
         dev_q <= '{default: '0};
         shf_q <= '{default: '0};
         steps_q <= '{default: '0};
      end else if (wr_fire) begin
         case ({waddr_q[5:2], 2'b00})
            OFS_R0: r0_q <= wd_m;
            OFS_R1: r1_q <= wd_m;
            OFS_R2: r2_q <= wd_m;
            OFS_R3: r3_q <= wd_m;
            OFS_R4: begin
               r4_q <= wd_m;
               second_clock_divider_q[wd_m[B_DIV_SEL]] <= wd_m[SECOND_CLOCK_DIVIDER_HI:SECOND_CLOCK_DIVIDER_LO];
            end
            OFS_R5: begin
               r5_q <= wd_m;
               dev_q[wd_m[B_SET_SEL]] <= wd_m[DEV_HI:DEV_LO];
               shf_q[wd_m[B_SET_SEL]] <= wd_m[SHF_HI:SHF_LO];
            end
            OFS_R6: begin
               r6_q <= wd_m;
               steps_q[wd_m[B_SET_SEL]] <= wd_m[STEPS_HI:STEPS_LO];
            end
            OFS_R7: r7_q <= wd_m;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and phase detector tick
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {trig_s1_q, trig_s2_q, trig_s3_q} <= '0;
         {rck_s1_q, rck_s2_q, rck_s3_q} <= '0;
      end else begin
         {trig_s1_q, trig_s2_q, trig_s3_q} <= {trigger_pin, trig_s1_q,
            trig_s2_q};
         {rck_s1_q, rck_s2_q, rck_s3_q} <= {readback_clk_pin, rck_s1_q,
            rck_s2_q};
      end
   end
   assign trig_rise = trig_s2_q && !trig_s3_q;
   assign rck_rise = rck_s2_q && !rck_s3_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pfd_cnt_q <= '0;
      end else begin
         pfd_cnt_q <= pfd_tick ? '0 : pfd_cnt_q + 3'h1;
      end
   end
   assign pfd_tick = pfd_cnt_q == PFD_DIV_LAST;

   // ----------------------------------------------------------------
   // Sweep engine
   // ----------------------------------------------------------------
   assign rtype = r3_q[RTYPE_HI:RTYPE_LO];
   assign running = (st_q == ST_UP || st_q == ST_DOWN) && !halted_q;
   assign fast_on = r7_q[B_FAST_RAMP] && rtype == RT_TRI;
   assign ramp_set = fast_on && st_q == ST_DOWN;
   assign parab_on = r5_q[B_PARAB];
   assign ext_on = r5_q[B_EXT_STEP];
   assign dev_w = N_W'($signed(dev_q[ramp_set])) <<< shf_q[ramp_set];
   // Product trimmed to the word width; callers keep steps small
   // Step numbers count from one, so the first step already moves
   assign inc_w = parab_on ? N_W'(dev_w * $signed({1'b0, 20'(step_idx_q
      + 20'h1)})) : dev_w;
   // Internal ramp clock is bypassed in external step mode
   assign step_ev = running && (ext_on ? trig_rise
      : pfd_tick && timer_q == '0);
   assign step_end = 20'(step_idx_q + 20'h1) == steps_q[ramp_set];
   assign n_word = {r0_q[INT_HI:INT_LO], r0_q[FMSB_HI:FMSB_LO],
      r1_q[FLSB_HI:FLSB_LO]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_q <= '0;
      end else if (r0_wr || step_ev) begin
         timer_q <= 24'(r2_q[FIRST_CLOCK_DIVIDER_HI:FIRST_CLOCK_DIVIDER_LO] * second_clock_divider_q[ramp_set] - 24'h1);
      end else if (pfd_tick && running && !ext_on && timer_q != '0) begin
         timer_q <= timer_q - 24'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_IDLE;
         freq_q <= '0;
         base_q <= '0;
         step_idx_q <= '0;
         done_q <= 1'b0;
      end else if (r0_wr) begin
         freq_q <= {wd_m[INT_HI:INT_LO], wd_m[FMSB_HI:FMSB_LO],
            r1_q[FLSB_HI:FLSB_LO]};
         base_q <= {wd_m[INT_HI:INT_LO], wd_m[FMSB_HI:FMSB_LO],
            r1_q[FLSB_HI:FLSB_LO]};
         step_idx_q <= '0;
         done_q <= 1'b0;
         // Type must already be chosen when start is written
         st_q <= wd_m[B_RAMP_START] ? ST_UP : ST_IDLE;
      end else if (step_ev) begin
         done_q <= 1'b0;
         unique case (st_q)
            ST_UP: begin
               freq_q <= N_W'($signed(freq_q) + inc_w);
               step_idx_q <= 20'(step_idx_q + 20'h1);
               if (r3_q[B_CNT_RST]) begin
                  step_idx_q <= '0;
               end else if (step_end) begin
                  step_idx_q <= '0;
                  if (rtype == RT_TRI) begin
                     st_q <= ST_DOWN;
                  end else if (rtype == RT_BURST) begin
                     st_q <= ST_DONE;
                     done_q <= 1'b1;
                  end else begin
                     freq_q <= base_q;
                     done_q <= 1'b1;
                  end
               end
            end
            ST_DOWN: begin
               freq_q <= N_W'($signed(freq_q) - inc_w);
               step_idx_q <= 20'(step_idx_q + 20'h1);
               if (step_end) begin
                  step_idx_q <= '0;
                  st_q <= ST_UP;
                  done_q <= 1'b1;
               end
            end
            ST_IDLE, ST_DONE: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Interrupt capture and serial readback
   // ----------------------------------------------------------------
   assign int_fire = trig_rise && r0_q[MUX_HI:MUX_LO] == MUX_RAMP_FN
      && r4_q[RBK_HI:RBK_LO] == RBK_INT
      && r5_q[IMODE_HI:IMODE_LO] != IM_OFF
      && (st_q == ST_UP || st_q == ST_DOWN);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         halted_q <= 1'b0;
      end else if (int_fire && r5_q[IMODE_HI:IMODE_LO] == IM_STOP) begin
         halted_q <= 1'b1;
      end else if (r0_wr) begin
         halted_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shreg_q <= '0;
         sh_cnt_q <= '0;
      end else if (int_fire) begin
         shreg_q <= freq_q;
         sh_cnt_q <= RBK_BITS;
      end else if (rck_rise && sh_cnt_q != '0) begin
         shreg_q <= {shreg_q[N_W-2:0], 1'b0};
         sh_cnt_q <= sh_cnt_q - 6'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         multiplexed_output_pin <= 1'b0;
      end else if (r0_q[MUX_HI:MUX_LO] != MUX_RAMP_FN) begin
         multiplexed_output_pin <= 1'b0;
      end else if (r4_q[RBK_HI:RBK_LO] == RBK_DONE) begin
         multiplexed_output_pin <= done_q;
      end else if (r4_q[RBK_HI:RBK_LO] == RBK_INT) begin
         multiplexed_output_pin <= shreg_q[N_W-1];
      end else begin
         multiplexed_output_pin <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Fast lock timer
   // ----------------------------------------------------------------
   assign fl_start = r0_wr && r4_q[DMODE_HI:DMODE_LO] == DM_FASTLOCK
      && !wd_m[B_RAMP_START];
   assign fl_active = fl_cnt_q != '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fl_cnt_q <= '0;
      end else if (fl_start) begin
         fl_cnt_q <= 24'(r2_q[FIRST_CLOCK_DIVIDER_HI:FIRST_CLOCK_DIVIDER_LO] * second_clock_divider_q[0]);
      end else if (st_q != ST_IDLE) begin
         fl_cnt_q <= '0;
      end else if (pfd_tick && fl_active) begin
         fl_cnt_q <= fl_cnt_q - 24'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_switch_pin_short <= 1'b0;
         second_switch_pin_link <= 1'b0;
         cp_current_mult <= CP_NORMAL;
      end else begin
         first_switch_pin_short <= fl_active;
         second_switch_pin_link <= fl_active;
         cp_current_mult <= fl_active ? CP_BOOST : CP_NORMAL;
      end
   end

   // ----------------------------------------------------------------
   // Modulator and status
   // ----------------------------------------------------------------
   assign sd.tick = pfd_tick;
   assign sd.frac = freq_q[FRAC_W-1:0];
   assign div_offset = sd.offset;
   assign stat_w = {freq_q[N_W-1:FRAC_W], 14'h0, sh_cnt_q != '0, fl_active,
      halted_q, done_q, st_q};

   rsr_sigma_delta u_sd (
      .aclk(aclk),
      .aresetn(aresetn),
      .sd(sd)
   );

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_start_goes_up: assert property (r0_wr && wd_m[B_RAMP_START]
      |=> st_q == ST_UP && step_idx_q == '0) else $error("start missed");
   a_parab_step: assert property (step_ev && st_q == ST_UP && !step_end
      && !r0_wr |=> freq_q == N_W'($signed($past(freq_q)) + $past(inc_w)))
      else $error("step increment wrong");
   a_linear_inc: assert property (!parab_on |-> inc_w == dev_w)
      else $error("nonlinear step without enable");
   a_down_set: assert property (step_ev && st_q == ST_DOWN && fast_on
      && !parab_on && !r0_wr |=> freq_q == N_W'($signed($past(freq_q))
      - (N_W'($signed($past(dev_q[1]))) <<< $past(shf_q[1]))))
      else $error("wrong parameter set on down slope");
   a_ext_step: assert property (step_ev && ext_on |-> trig_rise)
      else $error("external step without trigger");
   a_int_capture: assert property (int_fire |=> sh_cnt_q == RBK_BITS
      && shreg_q == $past(freq_q)) else $error("readback not captured");
   a_int_halt: assert property (int_fire && !r0_wr
      && r5_q[IMODE_HI:IMODE_LO] == IM_STOP |=> halted_q && !step_ev)
      else $error("halt mode kept sweeping");
   a_mux_done: assert property (r0_q[MUX_HI:MUX_LO] == MUX_RAMP_FN
      && r4_q[RBK_HI:RBK_LO] == RBK_DONE |=> multiplexed_output_pin
      == $past(done_q)) else $error("ramp complete not on pin");
   a_fl_length: assert property (fl_start |=> fl_cnt_q
      == 24'($past(r2_q[FIRST_CLOCK_DIVIDER_HI:FIRST_CLOCK_DIVIDER_LO]) * $past(second_clock_divider_q[0])))
      else $error("fast lock length wrong");
   a_fl_pins: assert property (fl_active |=> first_switch_pin_short
      && second_switch_pin_link && cp_current_mult == CP_BOOST)
      else $error("fast lock pins not set");
   a_rbk_shift: assert property (rck_rise && sh_cnt_q != '0 && !int_fire
      |=> sh_cnt_q == $past(sh_cnt_q) - 6'h1)
      else $error("readback shift missed");
   c_tri_turn: cover property (st_q == ST_UP ##1 st_q == ST_DOWN);
   c_int_stop: cover property (int_fire ##1 halted_q);
   c_fast_lock: cover property (fl_start ##1 fl_active);
endmodule : rsr_ramp_ctrl

// ---- src/rsr_pkg.sv ----
package rsr_pkg;
   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam logic [5:0] OFS_R0 = 6'h00;
   localparam logic [5:0] OFS_R1 = 6'h04;
   localparam logic [5:0] OFS_R2 = 6'h08;
   localparam logic [5:0] OFS_R3 = 6'h0C;
   localparam logic [5:0] OFS_R4 = 6'h10;
   localparam logic [5:0] OFS_R5 = 6'h14;
   localparam logic [5:0] OFS_R6 = 6'h18;
   localparam logic [5:0] OFS_R7 = 6'h1C;
   localparam logic [5:0] OFS_STAT = 6'h20;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int B_RAMP_START = 31;
   localparam int MUX_HI = 30, MUX_LO = 27;
   localparam int INT_HI = 26, INT_LO = 15;
   localparam int FMSB_HI = 14, FMSB_LO = 3;
   localparam int FLSB_HI = 27, FLSB_LO = 15;
   localparam int FIRST_CLOCK_DIVIDER_HI = 14, FIRST_CLOCK_DIVIDER_LO = 3;
   localparam int RTYPE_HI = 11, RTYPE_LO = 10;
   localparam int B_CNT_RST = 3;
   localparam int B_DIV_SEL = 6;
   localparam int SECOND_CLOCK_DIVIDER_HI = 18, SECOND_CLOCK_DIVIDER_LO = 7;
   localparam int DMODE_HI = 20, DMODE_LO = 19;
   localparam int RBK_HI = 25, RBK_LO = 21;
   localparam int DEV_HI = 18, DEV_LO = 3;
   localparam int SHF_HI = 22, SHF_LO = 19;
   localparam int B_SET_SEL = 23;
   localparam int B_PARAB = 28;
   localparam int B_EXT_STEP = 29;
   localparam int IMODE_HI = 27, IMODE_LO = 26;
   localparam int STEPS_HI = 22, STEPS_LO = 3;
   localparam int B_FAST_RAMP = 19;
   // ----------------------------------------------------------------
   // Codes and sizes
   // ----------------------------------------------------------------
   localparam logic [3:0] MUX_RAMP_FN = 4'hF;
   localparam logic [4:0] RBK_DONE = 5'h03;
   localparam logic [4:0] RBK_INT = 5'h02;
   localparam logic [1:0] RT_TRI = 2'h1;
   localparam logic [1:0] RT_BURST = 2'h3;
   localparam logic [1:0] IM_OFF = 2'h0;
   localparam logic [1:0] IM_STOP = 2'h3;
   localparam logic [1:0] DM_FASTLOCK = 2'h1;
   localparam logic [4:0] CP_NORMAL = 5'h01;
   localparam logic [4:0] CP_BOOST = 5'h10;
   localparam int INT_W = 12;
   localparam int FRAC_W = 25;
   localparam int N_W = INT_W + FRAC_W;
   localparam logic [5:0] RBK_BITS = 6'h25;
   // ----------------------------------------------------------------
   // Phase detector rate
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 125_000_000;
   localparam int PFD_HZ = 25_000_000;
   localparam logic [2:0] PFD_DIV_LAST = 3'(CLK_HZ / PFD_HZ - 1);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_UP = 2'b01,
      ST_DOWN = 2'b11,
      ST_DONE = 2'b10
   } rsr_ramp_state_type;
endpackage : rsr_pkg

// ---- src/rsr_sd_if.sv ----
`timescale 1ns/1ps
interface rsr_sd_if;
   logic tick;
   logic [24:0] frac;
   logic signed [3:0] offset;
   modport ctrl (output tick, output frac, input offset);
   modport fixed_modulus (input tick, input frac, output offset);
endinterface : rsr_sd_if

// ---- src/rsr_sigma_delta.sv ----
`timescale 1ns/1ps
module rsr_sigma_delta
   import rsr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   rsr_sd_if.fixed_modulus sd
);
   logic [FRAC_W-1:0] acc1_q, acc2_q, acc3_q;
   logic c2_q, c3_q, c3_qq;
   logic [FRAC_W:0] s1, s2, s3;
   logic signed [3:0] y;

   always_comb begin
      s1 = {1'b0, acc1_q} + {1'b0, sd.frac};
      s2 = {1'b0, acc2_q} + {1'b0, s1[FRAC_W-1:0]};
      s3 = {1'b0, acc3_q} + {1'b0, s2[FRAC_W-1:0]};
      // Three cascaded stages, carries recombined by differencing
      y = $signed({3'h0, s1[FRAC_W]}) + $signed({3'h0, s2[FRAC_W]})
         - $signed({3'h0, c2_q}) + $signed({3'h0, s3[FRAC_W]})
         - $signed({2'h0, c3_q, 1'b0}) + $signed({3'h0, c3_qq});
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc1_q <= '0;
         acc2_q <= '0;
         acc3_q <= '0;
         c2_q <= 1'b0;
         c3_q <= 1'b0;
         c3_qq <= 1'b0;
         sd.offset <= '0;
      end else if (sd.tick) begin
         acc1_q <= s1[FRAC_W-1:0];
         acc2_q <= s2[FRAC_W-1:0];
         acc3_q <= s3[FRAC_W-1:0];
         c2_q <= s2[FRAC_W];
         c3_q <= s3[FRAC_W];
         c3_qq <= c3_q;
         sd.offset <= y;
      end
   end

   a_sd_tick_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      !sd.tick |=> $stable(acc1_q) && $stable(sd.offset))
      else $error("modulator moved without a phase detector tick");
endmodule : rsr_sigma_delta

// ---- verif/rsr_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host controller pins: trigger and readback clock
// ----------------------------------------------------------------
module rsr_host_model (
   input wire logic aclk,
   input wire logic multiplexed_output_pin,
   output logic trigger_pin,
   output logic readback_clk_pin,
   output logic sampled_bit
);
   initial begin
      trigger_pin = 1'b0;
      readback_clk_pin = 1'b0;
      sampled_bit = 1'b0;
   end
   // Long high phase: the pin moves some cycles after the serial rise
   task automatic pulse(input bit rbk);
      @(posedge aclk);
      if (rbk) readback_clk_pin <= 1'b1;
      else trigger_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      sampled_bit <= multiplexed_output_pin;
      readback_clk_pin <= 1'b0;
      trigger_pin <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask : pulse
endmodule : rsr_host_model

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb
   import rsr_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, mux_pin, sw1, sw2;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp;
   logic [4:0] cp;
   logic trig, rclk, host_bit;
   logic signed [3:0] doff;
   logic [36:0] word;
   int err_count = 0, n_checks = 0, cyc = 0, off_sum = 0;
   rsr_ramp_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .trigger_pin(trig), .readback_clk_pin(rclk),
      .multiplexed_output_pin(mux_pin), .first_switch_pin_short(sw1),
      .second_switch_pin_link(sw2), .cp_current_mult(cp), .div_offset(doff));
   rsr_host_model i_host (.aclk(aclk), .multiplexed_output_pin(mux_pin),
      .trigger_pin(trig), .readback_clk_pin(rclk), .sampled_bit(host_bit));
   // ----------------------------------------------------------------
   // Bus tasks and checks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic ta, tw, tb_;
      ta = 0;
      tw = 0;
      tb_ = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb_) begin
         @(negedge aclk);
         ta = ta | (awready & awvalid);
         tw = tw | (wready & wvalid);
         tb_ = bvalid;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
   endtask : wr
   task automatic rd_reg(input logic [5:0] a);
      logic ta, got;
      got = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got) begin
         @(negedge aclk);
         ta = arvalid & arready;
         got = rvalid;
         if (got) rd = rdata;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
   endtask : rd_reg
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   // ----------------------------------------------------------------
   // Clock, reset, timeout, tests
   // ----------------------------------------------------------------
   initial begin
      aclk = 0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 0;
      awaddr = 0;
      araddr = 0;
      wdata = 0;
      aresetn = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      rd_reg(OFS_STAT);
      chk("status", 32'h0, rd);
      rd_reg(6'h24);
      chk("unmapped", {30'h0, RESP_SLVERR}, {rd[31:2], rresp});
      $display("test bus done");
      wr(OFS_R2, 32'h2 << 3);
      wr(OFS_R4, (32'h3 << 7) | (32'h1 << 19));
      wr(OFS_R0, 32'h0);
      repeat (2) @(posedge aclk);
      chk("boost", {27'h0, CP_BOOST}, {27'h0, cp});
      chk("switches", 32'h3, {30'h0, sw1, sw2});
      repeat (24) @(posedge aclk);
      chk("still on", {27'h0, CP_BOOST}, {27'h0, cp});
      repeat (20) @(posedge aclk);
      chk("boost end", {27'h0, CP_NORMAL}, {27'h0, cp});
      $display("test fast lock done");
      wr(OFS_R2, 32'h1 << 3);
      wr(OFS_R4, (32'h3 << 21) | (32'h1 << 7) | (32'h1 << 19));
      wr(OFS_R5, 32'h1 << 3);
      wr(OFS_R6, 32'h2 << 3);
      wr(OFS_R3, 32'h3 << 10);
      wr(OFS_R0, 32'hF800_0000);
      chk("no lock in ramp", {27'h0, CP_NORMAL}, {27'h0, cp});
      repeat (100) @(posedge aclk);
      rd_reg(OFS_STAT);
      chk("burst done", 32'h2, {30'h0, rd[1:0]});
      chk("ramp complete", 32'h1, {31'h0, mux_pin});
      $display("test ramp complete done");
      word = {12'hA5C, 12'h3C6, 13'h0F0F};
      wr(OFS_R4, (32'h2 << 21) | (32'h1 << 7));
      wr(OFS_R5, (32'h1 << 29) | (32'h3 << 26));
      wr(OFS_R3, 32'h1 << 10);
      wr(OFS_R1, 32'h0F0F << 15);
      wr(OFS_R0, 32'hF800_0000 | (32'hA5C << 15) | (32'h3C6 << 3));
      i_host.pulse(1'b0);
      chk("first bit", {31'h0, word[36]}, {31'h0, mux_pin});
      rd_reg(OFS_STAT);
      chk("halted", 32'h1, {31'h0, rd[3]});
      for (int i = 35; i >= 0; i--) begin
         i_host.pulse(1'b1);
         chk("readback bit", {31'h0, word[i]}, {31'h0, host_bit});
      end
      $display("test readback done");
      repeat (500) begin
         @(negedge aclk);
         off_sum += doff;
      end
      @(posedge aclk);
      chk("offset sum", 32'h1, {31'h0, off_sum > 60 && off_sum < 180});
      wr(OFS_R4, 32'h1 << 7);
      wr(OFS_R7, 32'h1 << 19);
      wr(OFS_R5, (32'h1 << 29) | (32'hF << 19) | (32'h800 << 3));
      wr(OFS_R5, 32'h2080_0000 | (32'hF << 19) | (32'h1000 << 3));
      wr(OFS_R6, 32'h4 << 3);
      wr(OFS_R6, (32'h1 << 23) | (32'h2 << 3));
      wr(OFS_R3, 32'h1 << 10);
      wr(OFS_R0, 32'h8000_0000 | (32'h10 << 15));
      repeat (4) i_host.pulse(1'b0);
      rd_reg(OFS_STAT);
      chk("fast top", 32'h0180_0003, {rd[31:20], 18'h0, rd[1:0]});
      repeat (2) i_host.pulse(1'b0);
      rd_reg(OFS_STAT);
      chk("fast bottom", 32'h0100_0001, {rd[31:20], 18'h0, rd[1:0]});
      $display("test fast ramp done");
      wr(OFS_R5, 32'h3000_0000 | (32'hF << 19) | (32'h400 << 3));
      wr(OFS_R3, (32'h3 << 10) | (32'h1 << 3));
      wr(OFS_R3, 32'h3 << 10);
      wr(OFS_R0, 32'h8000_0000 | (32'h10 << 15));
      repeat (4) i_host.pulse(1'b0);
      rd_reg(OFS_STAT);
      chk("parabolic", 32'h01A0_0002, {rd[31:20], 18'h0, rd[1:0]});
      $display("test parabolic done");
      final_report();
   end
endmodule : tb
